// file: testbench/pbank_props.sv
`timescale 1ns/100ps
module pbank_props
    import pbank_pkg::*;
#(
    parameter int TICK_CYCLES = 40000
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Inputs
    input wire logic button_i,
    input wire sense_t sense_i,
    input wire bat_above_t bat_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    // Outputs
    input wire gauge_t gauge_o,
    input wire logic torch_en_o,
    input wire logic boost_en_o,
    input wire logic path_gate_o,
    input wire chg_mode_t chg_mode_o,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_vin_gate_low: assert property (sense_i.vin_present [*8] |-> !path_gate_o)
        else $error("gate on with charger input");
    a_vin_gate_drop: assert property ($rose(sense_i.vin_present) && boost_en_o |-> ##[1:10] !path_gate_o)
        else $error("path gate not dropped on charger input");
    a_chg_no_boost: assert property (chg_mode_o != CHG_NONE |-> !boost_en_o)
        else $error("boost running while charging");
    a_chg_one_led: assert property (chg_mode_o != CHG_NONE |-> $countones(gauge_o) <= 1)
        else $error("more than one gauge LED while charging");
    a_low_no_start: assert property ($rose(torch_en_o) || $rose(boost_en_o) |-> bat_i.v3p1)
        else $error("torch or boost started on a low battery");
    a_hot_cuts_power: assert property (sense_i.die_hot [*8] |-> !boost_en_o && chg_mode_o == CHG_NONE)
        else $error("power stage on while hot");
    a_lockout_sleep: assert property (!sense_i.input_undervoltage_lockout_ok [*8] |-> chg_mode_o == CHG_NONE)
        else $error("charging below input lockout");
    a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_no_data: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("error answer carries data");
endmodule

bind power_bank_mode_indicator_ctrl pbank_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .button_i(button_i), .sense_i(sense_i),
    .bat_i(bat_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .gauge_o(gauge_o),
    .torch_en_o(torch_en_o), .boost_en_o(boost_en_o), .path_gate_o(path_gate_o),
    .chg_mode_o(chg_mode_o), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o)
);

// file: testbench/pbank_world.sv
`timescale 1ns/100ps
module pbank_world
    import pbank_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Bench controls
    input wire logic press_i,
    input wire logic [19:0] hold_i,
    input wire logic [12:0] bat_mv_i,
    // Device pins
    output logic button_o,
    output bat_above_t bat_o
);
    // Comparator levels in mV, top flag first; near-full trips a little below target.
    localparam int TH [12] = '{4150, 4070, 4020, 3870, 3850, 3720, 3710, 3550, 3430, 3200,
        3100, 2900};
    logic [19:0] left_q;
    logic [11:0] above;

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            above[11 - i] = int'(bat_mv_i) > TH[i];
        end
    end
    assign bat_o = bat_above_t'(above);

    // The key is held for exactly hold_i cycles, so the bench picks short or long.
    always_ff @(posedge ref_clk_i) begin
        if (press_i) begin
            left_q <= hold_i;
        end else if (left_q != 20'h0) begin
            left_q <= left_q - 20'h1;
        end
    end
    assign button_o = left_q != 20'h0;
endmodule

// file: testbench/power_bank_mode_indicator_ctrl_tb.sv
`timescale 1ns/100ps
module power_bank_mode_indicator_ctrl_tb;
    import pbank_pkg::*;
    localparam int TICK = 4;
    localparam logic [32:0] FULL = 33'h1_FFFF_FFFF;
    localparam logic [32:0] NO_G = 33'h1_FFFF_E1FF;
    localparam logic [32:0] NO_LOW = 33'h1_FFFF_FDFF;
    logic clk, nrst, button, press, psel, penable, pwrite, pready, pslverr, torch, boost, gate;
    logic [19:0] hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    sense_t sense;
    bat_above_t bat;
    gauge_t gauge;
    chg_mode_t mode;
    logic [32:0] exp_q[$], msk_q[$];
    int mv, err_count, n_compared;

    always #12.5 clk = ~clk;

    pbank_world i_world (.ref_clk_i(clk), .press_i(press), .hold_i(hold), .bat_mv_i(mv[12:0]),
        .button_o(button), .bat_o(bat));
    power_bank_mode_indicator_ctrl #(.TICK_CYCLES(TICK)) i_dut (.ref_clk_i(clk), .nrst_i(nrst),
        .button_i(button), .sense_i(sense), .bat_i(bat), .gauge_o(gauge), .torch_en_o(torch),
        .boost_en_o(boost), .path_gate_o(gate), .chg_mode_o(mode), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr));

    task print_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0, 4'hF);
    endtask

    task press_for(input int ticks);
        press <= 1'b1;
        hold <= 20'(ticks * TICK);
        @(posedge clk);
        press <= 1'b0;
        repeat (ticks * TICK + 40) @(posedge clk);
    endtask

    function automatic logic [32:0] st(input logic [3:0] s, input logic [1:0] md,
        input logic [2:0] tbg, input logic [3:0] g);
        return {20'h0, g, tbg, md, s};
    endfunction

    // ------------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n_compared++;
            if ((({pslverr, prdata} ^ exp_q[0]) & msk_q[0]) !== 33'h0) begin
                err_count++;
                $display("mismatch at %0t: got %h expected %h", $time,
                    {pslverr, prdata} & msk_q[0], exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        press = 1'b1;
        hold = 20'h0;
        sense = '0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        err_count = 0;
        n_compared = 0;
        void'($urandom(32'hC91C));
        mv = 3720 + $urandom % 120;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        press <= 1'b0;
        repeat (8) @(posedge clk);
        rd(CTRL_OFS, {31'h0, CTRL_RESET}, FULL);
        rd(STATUS_OFS, 33'h0, FULL);
        rd(12'h008, 33'h1_0000_0000, FULL);
        apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
        rd(STATUS_OFS, 33'h0, FULL);
        apb(1'b1, CTRL_OFS, 32'h1, 4'h0);
        rd(CTRL_OFS, 33'h3, FULL);
        apb(1'b1, CTRL_OFS, 32'h1, 4'hF);
        rd(CTRL_OFS, 33'h1, FULL);
        apb(1'b1, CTRL_OFS, 32'h3, 4'hF);
        press_for(100 + $urandom % 300);
        rd(STATUS_OFS, st(4'h1, 2'h0, 3'h3, 4'h7), FULL);
        repeat (int'(DISPLAY_MS) * TICK + 200) @(posedge clk);
        rd(STATUS_OFS, st(4'h1, 2'h0, 3'h3, 4'h0), NO_LOW);
        press_for(100);
        rd(STATUS_OFS, st(4'h1, 2'h0, 3'h3, 4'h7), FULL);
        press_for(2100);
        rd(STATUS_OFS, st(4'h1, 2'h0, 3'h7, 4'h0), NO_G);
        sense.vin_present <= 1'b1;
        sense.input_undervoltage_lockout_ok <= 1'b1;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, st(4'h3, 2'h2, 3'h4, 4'h0), NO_G);
        press_for(100);
        rd(STATUS_OFS, st(4'h3, 2'h2, 3'h4, 4'h0), NO_G);
        mv <= 2800;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, st(4'h2, 2'h1, 3'h4, 4'h0), NO_G);
        mv <= 4160;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, st(4'h4, 2'h3, 3'h4, 4'h0), NO_G);
        sense.chg_current_low <= 1'b1;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, st(4'h5, 2'h0, 3'h4, 4'hF), FULL);
        mv <= 4050;
        sense.chg_current_low <= 1'b0;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, st(4'h3, 2'h2, 3'h4, 4'h0), NO_G);
        sense.vin_present <= 1'b0;
        sense.input_undervoltage_lockout_ok <= 1'b0;
        repeat (200) @(posedge clk);
        rd(STATUS_OFS, st(4'h0, 2'h0, 3'h4, 4'h0), NO_G);
        mv <= 3800;
        sense.load_detect <= 1'b1;
        repeat (20) @(posedge clk);
        sense.load_detect <= 1'b0;
        rd(STATUS_OFS, st(4'h1, 2'h0, 3'h7, 4'h0), NO_G);
        sense.die_hot <= 1'b1;
        repeat (20) @(posedge clk);
        rd(STATUS_OFS, 33'h0, 33'h0_0000_00C0);
        sense.die_hot <= 1'b0;
        mv <= 3000;
        press_for(2100);
        rd(STATUS_OFS, 33'h0, 33'h0_0000_0100);
        press_for(2100);
        press_for(100);
        rd(STATUS_OFS, 33'h0, 33'h0_0000_01C0);
        @(posedge clk);
        print_verdict();
    end
endmodule

// file: verilog/pbank_pkg.sv
package pbank_pkg;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int PRE_W = 16;
    localparam int MS_W = 15;
    localparam int PHASE_W = 12;

    // Interval figures in milliseconds, one tick per millisecond.
    localparam logic [PHASE_W-1:0] PHASE_WRAP_MS = 12'hFA0;
    localparam logic [PHASE_W-1:0] CHG_BLINK_PERIOD_MS = 12'h3E8;
    localparam logic [PHASE_W-1:0] CHG_BLINK_ON_MS = 12'h1F4;
    localparam logic [PHASE_W-1:0] IDLE_BLINK_PERIOD_MS = 12'h7D0;
    localparam logic [PHASE_W-1:0] IDLE_BLINK_ON_MS = 12'h0FA;
    localparam logic [PHASE_W-1:0] LOW_BLINK_PERIOD_MS = 12'h0FA;
    localparam logic [PHASE_W-1:0] LOW_BLINK_ON_MS = 12'h07D;
    localparam logic [MS_W-1:0] SHORT_MIN_MS = 15'h003C;
    localparam logic [MS_W-1:0] LONG_MS = 15'h07D0;
    localparam logic [MS_W-1:0] DISPLAY_MS = 15'h0FA0;
    localparam logic [MS_W-1:0] LOAD_IDLE_MS = 15'h3E80;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
    localparam int CTRL_NTC_EN_BIT = 0;
    localparam int CTRL_AUTOLOAD_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_BOOST = 4'h1,
        ST_TRICKLE = 4'h2,
        ST_CC = 4'h3,
        ST_CV = 4'h4,
        ST_DONE = 4'h5,
        ST_RECHARGE = 4'h6,
        ST_CHG_HOLD = 4'h7
    } state_t;

    typedef enum logic [1:0] {
        CHG_NONE = 2'h0,
        CHG_TRICKLE = 2'h1,
        CHG_CC = 2'h2,
        CHG_CV = 2'h3
    } chg_mode_t;

    // Each bit is high while the battery is above the named level.
    typedef struct packed {
        logic v4p2_near;
        logic v4p07;
        logic v4p02;
        logic v3p87;
        logic v3p85;
        logic v3p72;
        logic v3p71;
        logic v3p55;
        logic v3p43;
        logic v3p2;
        logic v3p1;
        logic v2p9;
    } bat_above_t;

    typedef struct packed {
        logic input_undervoltage_lockout_ok;
        logic vin_present;
        logic chg_current_low;
        logic load_current_low;
        logic load_detect;
        logic die_hot;
        logic battery_thermistor_fault;
        logic battery_thermistor_grounded;
    } sense_t;

    typedef struct packed {
        logic button;
        sense_t sense;
        bat_above_t bat;
    } raw_in_t;

    typedef struct packed {
        logic gauge_led_top;
        logic gauge_led_third;
        logic gauge_led_second;
        logic gauge_led_lowest;
    } gauge_t;

    typedef struct packed {
        logic [18:0] rsvd;
        gauge_t gauge;
        logic torch;
        logic boost;
        logic path_gate;
        chg_mode_t mode;
        state_t state;
    } status_reg_t;

endpackage

// file: verilog/power_bank_mode_indicator_ctrl.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - Charging blinks only the LED of the battery band at 3.72/3.87/4.02 V.
// - Charging blink is 1 Hz with a 0.5 s on pulse.
// - At end-of-charge current, stop charging and light all four LEDs.
// - Boost gauge shows 4/3/2/1 LEDs at 3.85/3.71/3.55/3.43 V bands.
// - Boost at 3.43-3.2 V blinks a 4 Hz warning during the gauge display; below 3.2 V shuts down.
// - A short-press gauge display in boost stays for 4 s.
// - After the display, only the lowest LED blinks, 2 s period, 0.25 s on.
// - Input below lockout means sleep; above lockout enters charging.
// - Battery below 2.9 V while charging selects trickle charging.
// - Above trickle threshold, charge at constant current.
// - Nearing 4.2 V, move from constant current to constant voltage.
// - After end of charge, a drop to 4.07 V restarts a charge cycle.
// - Charging keeps boost off, ignores short presses, long press toggles torch.
// - Leaving charging mode goes to standby.
// - From shutdown, a short press or a load attach starts the boost.
// - Path gate high in boost operation, low when off, charging or faulted.
// - Input above 1.6 V while boosting drops the path gate at once.
// - After input removal, boost resumes only after a new press or a load attach.
// - Load below 20 mA for over 16 s stops boost into standby.
// - Die at 150 C cuts boost or stops charging.
// - Thermistor faults stop charging; grounded thermistor disables the check.
// - Press 60 ms to 2 s is short; over 2 s is long.
// - Each long press toggles the torch.
// - Below 3.1 V torch and boost cannot start; a lit torch stays on.
// - A further short press in boost shows the gauge 4 s again.
module power_bank_mode_indicator_ctrl
    import pbank_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Button and analog flags
    input wire logic button_i,
    input wire sense_t sense_i,
    input wire bat_above_t bat_i,
    // Indicators and power stage controls
    output gauge_t gauge_o,
    output logic torch_en_o,
    output logic boost_en_o,
    output logic path_gate_o,
    output chg_mode_t chg_mode_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o
);

    // ------------------------------------------------------------------
    // Input synchroniser and filter
    // ------------------------------------------------------------------
    localparam int IN_W = $bits(raw_in_t);

    raw_in_t raw;
    logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
    raw_in_t in_f;

    assign raw = '{button: button_i, sense: sense_i, bat: bat_i};

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit only moves once two later stages agree, which rejects single-cycle glitches.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filt_q <= '0;
        end else begin
            filt_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
        end
    end

    assign in_f = raw_in_t'(filt_q);

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    logic [PRE_W-1:0] pre_q;
    logic tick_q;
    logic [PHASE_W-1:0] phase_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_q == PRE_W'(TICK_CYCLES - 1)) begin
            pre_q <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // The phase wraps at a common multiple of all blink periods, so patterns never slip.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= '0;
        end else if (tick_q) begin
            phase_q <= (phase_q == PHASE_WRAP_MS - 1'b1) ? '0 : phase_q + 1'b1;
        end
    end

    function automatic logic blink(input logic [PHASE_W-1:0] ph,
                                   input logic [PHASE_W-1:0] period,
                                   input logic [PHASE_W-1:0] on_ms);
        blink = (ph % period) < on_ms;
    endfunction

    // ------------------------------------------------------------------
    // Button classification
    // ------------------------------------------------------------------
    logic [MS_W-1:0] press_q;
    logic short_press;
    logic long_press;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            press_q <= '0;
        end else if (tick_q) begin
            if (!in_f.button) begin
                press_q <= '0;
            end else if (press_q != LONG_MS) begin
                press_q <= press_q + 1'b1;
            end
        end
    end

    assign short_press = tick_q && !in_f.button && press_q > SHORT_MIN_MS
                         && press_q < LONG_MS;
    assign long_press = tick_q && in_f.button && press_q == LONG_MS - 1'b1;

    // ------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------
    state_t state_q, state_d;
    logic [1:0] ctrl_q;
    logic load_timeout;
    logic bat_temp_fault;
    logic chg_stop;
    logic in_charge;
    logic boost_start;
    logic [MS_W-1:0] load_q;

    assign bat_temp_fault = in_f.sense.battery_thermistor_fault
                            && !in_f.sense.battery_thermistor_grounded
                            && ctrl_q[CTRL_NTC_EN_BIT];
    assign chg_stop = in_f.sense.die_hot || bat_temp_fault;
    assign in_charge = state_q inside {ST_TRICKLE, ST_CC, ST_CV, ST_DONE, ST_RECHARGE,
                                       ST_CHG_HOLD};
    assign boost_start = (short_press
                          || (in_f.sense.load_detect && ctrl_q[CTRL_AUTOLOAD_EN_BIT]))
                         && in_f.bat.v3p1 && !in_f.sense.die_hot;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (in_f.sense.input_undervoltage_lockout_ok) begin
                    state_d = ST_TRICKLE;
                end else if (boost_start && !in_f.sense.vin_present) begin
                    state_d = ST_BOOST;
                end
            end
            ST_BOOST: begin
                if (in_f.sense.vin_present) begin
                    state_d = in_f.sense.input_undervoltage_lockout_ok ? ST_TRICKLE
                                                                       : ST_OFF;
                end else if (!in_f.bat.v3p2 || in_f.sense.die_hot || load_timeout) begin
                    state_d = ST_OFF;
                end
            end
            ST_TRICKLE: begin
                if (in_f.bat.v2p9) begin
                    state_d = ST_CC;
                end
            end
            ST_CC: begin
                if (!in_f.bat.v2p9) begin
                    state_d = ST_TRICKLE;
                end else if (in_f.bat.v4p2_near) begin
                    state_d = ST_CV;
                end
            end
            ST_CV: begin
                if (in_f.sense.chg_current_low) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!in_f.bat.v4p07) begin
                    state_d = ST_RECHARGE;
                end
            end
            ST_RECHARGE: state_d = ST_TRICKLE;
            ST_CHG_HOLD: begin
                if (!chg_stop) begin
                    state_d = ST_TRICKLE;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        // Charger faults and input loss override every charging state.
        if (state_d inside {ST_TRICKLE, ST_CC, ST_CV, ST_DONE, ST_RECHARGE} && chg_stop) begin
            state_d = ST_CHG_HOLD;
        end
        if (in_charge && !in_f.sense.input_undervoltage_lockout_ok) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Load idle timer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_q <= '0;
        end else if (state_q != ST_BOOST || !in_f.sense.load_current_low) begin
            load_q <= '0;
        end else if (tick_q && load_q != LOAD_IDLE_MS) begin
            load_q <= load_q + 1'b1;
        end
    end

    // Strictly longer than the idle limit: one more tick after reaching it.
    assign load_timeout = tick_q && in_f.sense.load_current_low
                          && load_q == LOAD_IDLE_MS;

    // ------------------------------------------------------------------
    // Gauge display timer
    // ------------------------------------------------------------------
    logic [MS_W-1:0] disp_q;
    logic disp_start;

    assign disp_start = short_press && ((state_q == ST_OFF && state_d == ST_BOOST)
                                        || state_q == ST_BOOST);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            disp_q <= '0;
        end else if (state_q != ST_BOOST && !disp_start) begin
            disp_q <= '0;
        end else if (disp_start) begin
            disp_q <= DISPLAY_MS;
        end else if (tick_q && disp_q != '0) begin
            disp_q <= disp_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Torch
    // ------------------------------------------------------------------
    logic torch_q;

    // Long press works in every state; a low battery only blocks switching on.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            torch_q <= 1'b0;
        end else if (long_press) begin
            if (torch_q) begin
                torch_q <= 1'b0;
            end else if (in_f.bat.v3p1) begin
                torch_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Gauge LED patterns
    // ------------------------------------------------------------------
    gauge_t gauge_d;
    logic chg_blink;

    assign chg_blink = blink(phase_q, CHG_BLINK_PERIOD_MS, CHG_BLINK_ON_MS);

    always_comb begin
        gauge_d = '0;
        case (state_q)
            ST_TRICKLE, ST_CC, ST_CV, ST_RECHARGE, ST_CHG_HOLD: begin
                if (in_f.bat.v4p02) begin
                    gauge_d.gauge_led_top = chg_blink;
                end else if (in_f.bat.v3p87) begin
                    gauge_d.gauge_led_third = chg_blink;
                end else if (in_f.bat.v3p72) begin
                    gauge_d.gauge_led_second = chg_blink;
                end else begin
                    gauge_d.gauge_led_lowest = chg_blink;
                end
            end
            ST_DONE: begin
                gauge_d = '1;
            end
            ST_BOOST: begin
                if (disp_q == '0) begin
                    gauge_d.gauge_led_lowest = blink(phase_q, IDLE_BLINK_PERIOD_MS,
                                                     IDLE_BLINK_ON_MS);
                end else if (!in_f.bat.v3p43) begin
                    gauge_d.gauge_led_lowest = blink(phase_q, LOW_BLINK_PERIOD_MS,
                                                     LOW_BLINK_ON_MS);
                end else begin
                    gauge_d.gauge_led_lowest = 1'b1;
                    gauge_d.gauge_led_second = in_f.bat.v3p55;
                    gauge_d.gauge_led_third = in_f.bat.v3p71;
                    gauge_d.gauge_led_top = in_f.bat.v3p85;
                end
            end
            default: gauge_d = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Power stage outputs
    // ------------------------------------------------------------------
    chg_mode_t mode_d;

    always_comb begin
        case (state_q)
            ST_TRICKLE: mode_d = CHG_TRICKLE;
            ST_CC: mode_d = CHG_CC;
            ST_CV: mode_d = CHG_CV;
            default: mode_d = CHG_NONE;
        endcase
    end

    // Boost and gate follow the next state, so the gate drops one edge before chg_mode_o changes.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gauge_o <= '0;
            torch_en_o <= 1'b0;
            boost_en_o <= 1'b0;
            path_gate_o <= 1'b0;
            chg_mode_o <= CHG_NONE;
        end else begin
            gauge_o <= gauge_d;
            torch_en_o <= torch_q;
            boost_en_o <= state_d == ST_BOOST;
            path_gate_o <= state_d == ST_BOOST;
            chg_mode_o <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // APB register slave
    // ------------------------------------------------------------------
    status_reg_t status;
    logic mapped;

    assign mapped = paddr_i == CTRL_OFS || paddr_i == STATUS_OFS;

    always_comb begin
        status = '0;
        status.gauge = gauge_o;
        status.torch = torch_en_o;
        status.boost = boost_en_o;
        status.path_gate = path_gate_o;
        status.mode = chg_mode_o;
        status.state = state_q;
    end

    // One wait state: data and error are registered on the edge that raises pready.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o <= 1'b0;
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o <= 1'b1;
            pslverr_o <= !mapped;
            if (pwrite_i || !mapped) begin
                prdata_o <= '0;
            end else if (paddr_i == CTRL_OFS) begin
                prdata_o <= 32'(ctrl_q);
            end else begin
                prdata_o <= status;
            end
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i
                     && paddr_i == CTRL_OFS && pstrb_i[0]) begin
            ctrl_q <= pwdata_i[1:0];
        end
    end

endmodule
